// file: rtl/asfs_pins.sv
// module: frame sync and receive bit clock pin routing with serial flags
//
// Summary of operation
// - asynchronous: receive sync pin serves all receivers
// - synchronous, buffer select 0: pin is flag 1
// - synchronous, select 1, direction 1: buffer enable
// - flag 1 direction follows receive sync direction bit
// - output flag 1 drives receive sync pin
// - output flag updates per frame or slot
// - input flag 1 sampled per frame or slot
// - synchronous: transmit sync pin frames everything
// - asynchronous: transmit sync pin frames transmitters only
// - transmit sync pin direction from its bit
// - gpio pins are input, output or disconnected
// - reset leaves all pins gpio disconnected
// - bit clock pin: receiver clock or flag 0
module asfs_pins
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire asfs_pkg::asfs_cfg_t cfg,
    input wire asfs_pkg::asfs_gpio_t gpio,
    input wire asfs_pkg::asfs_core_t core,
    input wire logic output_flag_one,
    input wire logic output_flag_zero,
    input wire logic receive_frame_sync_pin_i,
    input wire logic transmit_frame_sync_pin_i,
    input wire logic receive_bit_clock_pin_i,
    output asfs_pkg::asfs_pin_t receive_frame_sync_pin,
    output asfs_pkg::asfs_pin_t transmit_frame_sync_pin,
    output asfs_pkg::asfs_pin_t receive_bit_clock_pin,
    output logic rx_frame_sync,
    output logic tx_frame_sync,
    output logic rx_bit_clock,
    output logic rx_bit_clock_rise,
    output logic input_flag_one,
    output logic input_flag_zero,
    output logic gpio_in_rfs,
    output logic gpio_in_tfs,
    output logic gpio_in_sck
);

    // whole block state in one record
    typedef struct packed {
        logic rfs_m; // receive sync pin, first sync stage
        logic rfs_s; // receive sync pin, second sync stage
        logic tfs_m; // transmit sync pin, first sync stage
        logic tfs_s; // transmit sync pin, second sync stage
        logic sck_m; // bit clock pin, first sync stage
        logic sck_s; // bit clock pin, second sync stage
        logic sck_prev; // bit clock level one sample back
        logic fs_prev; // flag frame sync one sample back
        logic of1_hold; // flag 1 level shown at the pin
        logic of0_hold; // flag 0 level shown at the pin
        logic if1; // captured input flag 1
        logic if0; // captured input flag 0
        asfs_pkg::asfs_pin_t rfs_pin; // receive sync pin drive
        asfs_pkg::asfs_pin_t tfs_pin; // transmit sync pin drive
        asfs_pkg::asfs_pin_t sck_pin; // bit clock pin drive
        logic rx_fs; // frame sync handed to receivers
        logic tx_fs; // frame sync handed to transmitters
        logic rx_clk; // bit clock handed to receivers
        logic rx_clk_rise; // one-cycle pulse on bit clock rise
        logic gin_rfs; // gpio read of receive sync pin
        logic gin_tfs; // gpio read of transmit sync pin
        logic gin_sck; // gpio read of bit clock pin
    } asfs_state_t;

    asfs_state_t state_r; // registered state
    asfs_state_t state_nxt; // next state

    logic tfs_eff; // transmit frame sync as the port sees it
    logic rfs_eff; // receive pin frame sync as the port sees it
    logic sck_eff; // receive bit clock as the port sees it
    logic flag_evt; // moment at which flags move
    logic flag_mode; // synchronous: pins act as serial flags

    // gpio drive for one pin; disconnected and input both release it
    function automatic asfs_pkg::asfs_pin_t asfs_gpio_drive
    (
        input logic [1:0] mode,
        input logic data
    );
        asfs_pkg::asfs_pin_t p;
        p.o = asfs_pkg::ASFS_RST_LEVEL;
        p.oe = asfs_pkg::ASFS_RST_OE;
        if (mode == asfs_pkg::ASFS_GPIO_OUT)
        begin
            p.o = data;
            p.oe = 1'b1;
        end
        return p;
    endfunction : asfs_gpio_drive

    // gpio read for one pin; disconnected pins read as zero
    function automatic logic asfs_gpio_read
    (
        input logic [1:0] mode,
        input logic level
    );
        return (mode == asfs_pkg::ASFS_GPIO_IN) ? level : 1'b0;
    endfunction : asfs_gpio_read

    // drive for a pin that is simply an input or an output of the core
    function automatic asfs_pkg::asfs_pin_t asfs_dir_drive
    (
        input logic dir_out,
        input logic data
    );
        asfs_pkg::asfs_pin_t p;
        p.o = dir_out ? data : asfs_pkg::ASFS_RST_LEVEL;
        p.oe = dir_out;
        return p;
    endfunction : asfs_dir_drive

    // effective sync and clock levels and the flag timing event
    always_comb
    begin
        flag_mode = cfg.synchronous_operation_bit;
        tfs_eff = cfg.transmit_frame_sync_direction ? core.tx_fs
                                                    : state_r.tfs_s;
        if (!cfg.tfs_serial_en)
        begin
            tfs_eff = 1'b0;
        end
        rfs_eff = cfg.receive_frame_sync_direction ? core.rx_fs
                                                   : state_r.rfs_s;
        if (!cfg.rfs_serial_en)
        begin
            rfs_eff = 1'b0;
        end
        sck_eff = cfg.receive_clock_direction ? core.rx_clk : state_r.sck_s;
        if (!cfg.sck_serial_en)
        begin
            sck_eff = 1'b0;
        end
        // frame rise in normal mode, slot in network mode
        flag_evt = cfg.network_mode ? core.slot_start
                                    : (tfs_eff & ~state_r.fs_prev);
    end

    // next state: sync stages, pin routing and flag capture
    always_comb
    begin
        state_nxt = state_r;
        if (clk_en)
        begin
            // first stage feeds only the second
            state_nxt.rfs_m = receive_frame_sync_pin_i;
            state_nxt.rfs_s = state_r.rfs_m;
            state_nxt.tfs_m = transmit_frame_sync_pin_i;
            state_nxt.tfs_s = state_r.tfs_m;
            state_nxt.sck_m = receive_bit_clock_pin_i;
            state_nxt.sck_s = state_r.sck_m;
            state_nxt.sck_prev = sck_eff;
            state_nxt.fs_prev = tfs_eff;

            // flag outputs move only at the flag event
            if (flag_evt)
            begin
                state_nxt.of1_hold = output_flag_one;
                state_nxt.of0_hold = output_flag_zero;
            end

            // receive frame sync pin
            if (!cfg.rfs_serial_en)
            begin
                state_nxt.rfs_pin = asfs_gpio_drive(gpio.mode_rfs,
                                                    gpio.out_rfs);
                state_nxt.gin_rfs = asfs_gpio_read(gpio.mode_rfs,
                                                   state_r.rfs_s);
            end
            else if (!flag_mode)
            begin
                // sync in or out for all receivers
                state_nxt.rfs_pin = asfs_dir_drive(
                    cfg.receive_frame_sync_direction, core.rx_fs);
                state_nxt.gin_rfs = 1'b0;
            end
            else if (cfg.transmit_buffer_enable_select)
            begin
                // buffer enable only with output direction
                state_nxt.rfs_pin = asfs_dir_drive(
                    cfg.receive_frame_sync_direction, core.tx_buf_en);
                state_nxt.gin_rfs = 1'b0;
            end
            else
            begin
                // flag direction from receive sync bit
                // output flag 1 drives the pin
                state_nxt.rfs_pin = asfs_dir_drive(
                    cfg.receive_frame_sync_direction, state_r.of1_hold);
                state_nxt.gin_rfs = 1'b0;
                // input flag 1 sampled at the event
                if (!cfg.receive_frame_sync_direction && flag_evt)
                begin
                    state_nxt.if1 = state_r.rfs_s;
                end
            end

            // transmit frame sync pin
            if (!cfg.tfs_serial_en)
            begin
                state_nxt.tfs_pin = asfs_gpio_drive(gpio.mode_tfs,
                                                    gpio.out_tfs);
                state_nxt.gin_tfs = asfs_gpio_read(gpio.mode_tfs,
                                                   state_r.tfs_s);
            end
            else
            begin
                state_nxt.tfs_pin = asfs_dir_drive(
                    cfg.transmit_frame_sync_direction, core.tx_fs);
                state_nxt.gin_tfs = 1'b0;
            end

            // receive bit clock pin
            if (!cfg.sck_serial_en)
            begin
                state_nxt.sck_pin = asfs_gpio_drive(gpio.mode_sck,
                                                    gpio.out_sck);
                state_nxt.gin_sck = asfs_gpio_read(gpio.mode_sck,
                                                   state_r.sck_s);
            end
            else if (!flag_mode)
            begin
                state_nxt.sck_pin = asfs_dir_drive(
                    cfg.receive_clock_direction, core.rx_clk);
                state_nxt.gin_sck = 1'b0;
            end
            else
            begin
                // serial flag 0 in synchronous mode
                state_nxt.sck_pin = asfs_dir_drive(
                    cfg.receive_clock_direction, state_r.of0_hold);
                state_nxt.gin_sck = 1'b0;
                if (!cfg.receive_clock_direction && flag_evt)
                begin
                    state_nxt.if0 = state_r.sck_s;
                end
            end

            // asynchronous, transmit sync frames transmitters only
            state_nxt.tx_fs = tfs_eff;
            state_nxt.rx_fs = flag_mode ? tfs_eff : rfs_eff;
            // synchronous receivers run on the transmit side clock,
            // which lives outside this block, so the pin clock is gated
            state_nxt.rx_clk = flag_mode ? 1'b0 : sck_eff;
            state_nxt.rx_clk_rise = ~flag_mode & sck_eff & ~state_r.sck_prev;
        end
    end

    // state register; all-zero reset releases every pin
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
        begin
            // pins come out of reset disconnected
            state_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
        end
    end

    // outputs straight from the state register
    assign receive_frame_sync_pin = state_r.rfs_pin;
    assign transmit_frame_sync_pin = state_r.tfs_pin;
    assign receive_bit_clock_pin = state_r.sck_pin;
    assign rx_frame_sync = state_r.rx_fs;
    assign tx_frame_sync = state_r.tx_fs;
    assign rx_bit_clock = state_r.rx_clk;
    assign rx_bit_clock_rise = state_r.rx_clk_rise;
    assign input_flag_one = state_r.if1;
    assign input_flag_zero = state_r.if0;
    assign gpio_in_rfs = state_r.gin_rfs;
    assign gpio_in_tfs = state_r.gin_tfs;
    assign gpio_in_sck = state_r.gin_sck;

endmodule : asfs_pins

// file: rtl/asfs_pkg.sv
// package: shared constants and carrier types for the frame sync pin block
package asfs_pkg;

    // gpio mode encodings, one per pin
    localparam logic [1:0] ASFS_GPIO_OFF = 2'h0; // internally disconnected
    localparam logic [1:0] ASFS_GPIO_IN = 2'h1; // pin read as input
    localparam logic [1:0] ASFS_GPIO_OUT = 2'h2; // pin driven from data bit

    // reset values of held flag and pin state
    localparam logic ASFS_RST_LEVEL = 1'b0; // every held bit clears
    localparam logic ASFS_RST_OE = 1'b0; // pins released at reset

    // one driven pin: level and output enable
    typedef struct packed {
        logic o; // level driven onto the pin
        logic oe; // high while this block drives the pin
    } asfs_pin_t;

    // serial port configuration bits, from the core on clk_sys
    typedef struct packed {
        logic rfs_serial_en; // receive frame sync pin owned by the port
        logic tfs_serial_en; // transmit frame sync pin owned by the port
        logic sck_serial_en; // receive bit clock pin owned by the port
        logic synchronous_operation_bit; // one shared frame sync and clock
        logic transmit_buffer_enable_select; // pin carries buffer enable
        logic receive_frame_sync_direction; // 1: receive sync pin is output
        logic transmit_frame_sync_direction; // 1: transmit sync pin output
        logic receive_clock_direction; // 1: receive bit clock pin output
        logic network_mode; // flags follow slots, not frames
    } asfs_cfg_t;

    // gpio settings for the three pins
    typedef struct packed {
        logic [1:0] mode_rfs; // gpio_line_receive_sync mode
        logic [1:0] mode_tfs; // gpio_line_transmit_sync mode
        logic [1:0] mode_sck; // receive bit clock gpio mode
        logic out_rfs; // gpio_line_receive_sync output data
        logic out_tfs; // gpio_line_transmit_sync output data
        logic out_sck; // receive bit clock gpio output data
    } asfs_gpio_t;

    // signals sourced by the serial core on clk_sys
    typedef struct packed {
        logic rx_fs; // receiver frame sync when generated inside
        logic tx_fs; // transmitter frame sync when generated inside
        logic rx_clk; // receiver bit clock when generated inside
        logic tx_buf_en; // transmitter external buffer enable
        logic slot_start; // one-cycle pulse at each network slot
    } asfs_core_t;

endpackage : asfs_pkg

// file: sim/asfs_codec_model.sv
// model: external codec on the far side of the frame sync pins
module asfs_codec_model
(
    input wire logic run,
    input wire logic rfs_drv,
    input wire logic rfs_lvl,
    input wire asfs_pkg::asfs_pin_t rfs_pin,
    input wire asfs_pkg::asfs_pin_t tfs_pin,
    input wire asfs_pkg::asfs_pin_t sck_pin,
    output logic rfs_w,
    output logic tfs_w,
    output logic sck_w
);
    timeunit 1ns;
    timeprecision 1ns;
    logic sck = 1'h0; // codec bit clock, still between frames
    logic [1:0] cnt = 2'h0; // bit count within one frame
    logic flip = 1'h0; // junk on a released line, never a held value
    // 400 ns bit clock only while frames run
    always #200 sck = run ? ~sck : 1'h0;
    always #25 flip = ~flip;
    // one bit wide frame sync every four bits
    always @(posedge sck) cnt <= cnt + 2'h1;
    // the block wins whenever it drives a pin
    assign rfs_w = rfs_pin.oe ? rfs_pin.o : (rfs_drv ? rfs_lvl : flip);
    assign tfs_w = tfs_pin.oe ? tfs_pin.o : (run ? cnt == 2'h0 : flip);
    assign sck_w = sck_pin.oe ? sck_pin.o : (run ? sck : flip);
endmodule : asfs_codec_model

// file: sim/asfs_pins_asserts.sv
// checker: port-level properties of the frame sync pin block
module asfs_pins_asserts
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic clk_en,
    input wire asfs_pkg::asfs_cfg_t cfg,
    input wire asfs_pkg::asfs_gpio_t gpio,
    input wire asfs_pkg::asfs_core_t core,
    input wire logic output_flag_one,
    input wire asfs_pkg::asfs_pin_t receive_frame_sync_pin,
    input wire asfs_pkg::asfs_pin_t transmit_frame_sync_pin,
    input wire logic rx_frame_sync,
    input wire logic tx_frame_sync
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic live_r; // last edge was out of reset and enabled
    logic flag_cfg; // receive sync pin is output flag, slot timed
    // outputs only answer inputs taken on a live edge
    always_ff @(posedge clk_sys or negedge reset_n)
    begin
        if (!reset_n)
            live_r <= 1'h0;
        else
            live_r <= clk_en;
    end
    assign flag_cfg = cfg.rfs_serial_en && cfg.synchronous_operation_bit &&
        !cfg.transmit_buffer_enable_select &&
        cfg.receive_frame_sync_direction && cfg.network_mode;
    tfs_drive_a: assert property (
        live_r && $past(cfg.tfs_serial_en) |-> transmit_frame_sync_pin.oe ==
        $past(cfg.transmit_frame_sync_direction) &&
        (!transmit_frame_sync_pin.oe ||
        transmit_frame_sync_pin.o == $past(core.tx_fs)))
        else $error("transmit sync drive wrong");
    rfs_async_a: assert property (
        live_r && $past(cfg.rfs_serial_en && cfg.receive_frame_sync_direction
        && !cfg.synchronous_operation_bit) |-> receive_frame_sync_pin.oe &&
        receive_frame_sync_pin.o == $past(core.rx_fs))
        else $error("receive sync drive wrong");
    rx_shared_a: assert property (
        live_r && $past(cfg.synchronous_operation_bit && cfg.rfs_serial_en &&
        cfg.tfs_serial_en) |-> rx_frame_sync == tx_frame_sync)
        else $error("shared frame sync differs");
    buf_enable_a: assert property (
        live_r && $past(cfg.rfs_serial_en && cfg.synchronous_operation_bit &&
        cfg.transmit_buffer_enable_select) |-> receive_frame_sync_pin.oe ==
        $past(cfg.receive_frame_sync_direction) &&
        (!receive_frame_sync_pin.oe ||
        receive_frame_sync_pin.o == $past(core.tx_buf_en)))
        else $error("buffer enable drive wrong");
    gpio_mode_a: assert property (
        live_r && !$past(cfg.rfs_serial_en) |-> receive_frame_sync_pin.oe ==
        ($past(gpio.mode_rfs) == asfs_pkg::ASFS_GPIO_OUT) &&
        (!receive_frame_sync_pin.oe ||
        receive_frame_sync_pin.o == $past(gpio.out_rfs)))
        else $error("gpio drive wrong");
    reset_release_a: assert property (
        $rose(reset_n) |-> !receive_frame_sync_pin.oe &&
        !transmit_frame_sync_pin.oe) else $error("pin driven after reset");
    // the hold register loads at the slot edge, the pin one edge later
    flag_out_a: assert property (
        live_r && $past(live_r) && $past(core.slot_start, 2) && flag_cfg &&
        $stable(cfg) && $past(cfg) == $past(cfg, 2) |->
        receive_frame_sync_pin.oe &&
        receive_frame_sync_pin.o == $past(output_flag_one, 2))
        else $error("output flag not shown");
    flag_hold_a: assert property (
        live_r && $past(live_r) && !$past(core.slot_start, 2) && flag_cfg &&
        $stable(cfg) && $past(cfg) == $past(cfg, 2) |->
        $stable(receive_frame_sync_pin.o)) else $error("flag moved early");
endmodule : asfs_pins_asserts

// file: sim/asfs_pins_tb.sv
// testbench: directed scenarios for the frame sync pin block
module asfs_pins_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_sys = 1'h0;
    logic reset_n = 1'h0;
    logic clk_en = 1'h1;
    asfs_pkg::asfs_cfg_t cfg = '0;
    asfs_pkg::asfs_gpio_t gpio = '0;
    asfs_pkg::asfs_core_t core = '0;
    logic of1 = 1'h0; // output flag one value from software
    logic of0 = 1'h0; // output flag zero value from software
    logic if0, g_tfs, g_sck; // flag zero and gpio reads
    logic run = 1'h0; // codec frames on
    logic rfs_drv = 1'h0; // codec drives receive sync line
    logic rfs_lvl = 1'h0;
    logic rfs_w, tfs_w, sck_w, rx_fs, tx_fs, rx_bck, rx_rise, if1, g_rfs;
    asfs_pkg::asfs_pin_t rfs_p, tfs_p, sck_p;
    int err_count = 0;
    int tests_run = 0;
    always #25 clk_sys = ~clk_sys;
    asfs_pins dut (.clk_sys(clk_sys), .reset_n(reset_n), .clk_en(clk_en),
        .cfg(cfg), .gpio(gpio), .core(core), .output_flag_one(of1),
        .output_flag_zero(of0), .receive_frame_sync_pin_i(rfs_w),
        .transmit_frame_sync_pin_i(tfs_w), .receive_bit_clock_pin_i(sck_w),
        .receive_frame_sync_pin(rfs_p), .transmit_frame_sync_pin(tfs_p),
        .receive_bit_clock_pin(sck_p), .rx_frame_sync(rx_fs),
        .tx_frame_sync(tx_fs), .rx_bit_clock(rx_bck),
        .rx_bit_clock_rise(rx_rise), .input_flag_one(if1),
        .input_flag_zero(if0), .gpio_in_rfs(g_rfs), .gpio_in_tfs(g_tfs),
        .gpio_in_sck(g_sck));
    asfs_codec_model codec (.run(run), .rfs_drv(rfs_drv), .rfs_lvl(rfs_lvl),
        .rfs_pin(rfs_p), .tfs_pin(tfs_p), .sck_pin(sck_p), .rfs_w(rfs_w),
        .tfs_w(tfs_w), .sck_w(sck_w));
    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out();
        $display("mismatches %0d comparisons %0d", err_count, tests_run);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out
    // inputs move on falling edges only
    task automatic step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : step
    task automatic slot();
        core.slot_start = 1'h1;
        step(1);
        core.slot_start = 1'h0;
    endtask : slot
    // released after reset, then every gpio mode code
    task automatic t_gpio();
        check({rfs_p.oe, tfs_p.oe, sck_p.oe, g_rfs}, 4'h0);
        rfs_drv = 1'h1;
        rfs_lvl = 1'h1;
        gpio.out_rfs = 1'h1;
        gpio.out_sck = 1'h1;
        for (int m = 0; m < 4; m++)
        begin
            gpio.mode_rfs = 2'(m);
            gpio.mode_tfs = 2'(m);
            gpio.mode_sck = 2'(m);
            step(4);
            check({rfs_p.oe, tfs_p.oe, g_rfs}, {{2{m == 2}}, m == 1});
            check({sck_p.oe, sck_p.o}, {2{m == 2}});
            // released tfs and sck lines carry junk, so reads are checked only when not input
            if (m != 1)
            begin
                check({g_tfs, g_sck}, 2'h0);
            end
        end
        gpio = '0;
    endtask : t_gpio
    // transmit sync frames receivers only when synchronous
    task automatic t_frames();
        logic seen_tx, seen_rx;
        cfg.rfs_serial_en = 1'h1;
        cfg.tfs_serial_en = 1'h1;
        rfs_lvl = 1'h0;
        run = 1'h1;
        // let the old high level drain out of the sync stages
        step(3);
        for (int s = 0; s < 2; s++)
        begin
            cfg.synchronous_operation_bit = 1'(s);
            seen_tx = 1'h0;
            seen_rx = 1'h0;
            repeat (40)
            begin
                step(1);
                seen_tx |= tx_fs;
                seen_rx |= rx_fs;
            end
            check({seen_tx, seen_rx}, {1'h1, 1'(s)});
        end
        run = 1'h0;
        cfg.synchronous_operation_bit = 1'h0;
        cfg.receive_frame_sync_direction = 1'h1;
        cfg.transmit_frame_sync_direction = 1'h1;
        for (int v = 0; v < 2; v++)
        begin
            core.rx_fs = 1'(v);
            core.tx_fs = 1'(1 - v);
            step(2);
            check({rfs_p.oe, rfs_p.o}, {1'h1, 1'(v)});
            check({tfs_p.oe, tfs_p.o, tx_fs}, {1'h1, {2{1'(1 - v)}}});
        end
        // clock enable low freezes the pin drive
        clk_en = 1'h0;
        core.rx_fs = 1'h0;
        step(3);
        check({rfs_p.oe, rfs_p.o}, 2'h3);
        clk_en = 1'h1;
    endtask : t_frames
    // output and input flag one, then buffer enable
    task automatic t_flags();
        core = '0;
        cfg.synchronous_operation_bit = 1'h1;
        cfg.network_mode = 1'h1;
        cfg.sck_serial_en = 1'h1;
        cfg.receive_clock_direction = 1'h1;
        of1 = 1'h1;
        of0 = 1'h1;
        step(3);
        check({rfs_p.o, sck_p.o}, 2'h0);
        slot();
        step(1);
        check({rfs_p.oe, rfs_p.o}, 2'h3);
        check({sck_p.oe, sck_p.o, if0}, 3'h6);
        cfg.network_mode = 1'h0;
        of1 = 1'h0;
        step(4);
        check(rfs_p.o, 1'h1);
        core.tx_fs = 1'h1;
        step(4);
        check(rfs_p.o, 1'h0);
        cfg.network_mode = 1'h1;
        cfg.receive_frame_sync_direction = 1'h0;
        rfs_lvl = 1'h1;
        step(4);
        check(rfs_p.oe, 1'h0);
        slot();
        step(3);
        check(if1, 1'h1);
        rfs_lvl = 1'h0;
        step(6);
        check(if1, 1'h1);
        slot();
        step(3);
        check(if1, 1'h0);
        cfg.transmit_buffer_enable_select = 1'h1;
        cfg.receive_frame_sync_direction = 1'h1;
        for (int v = 0; v < 2; v++)
        begin
            core.tx_buf_en = 1'(v);
            step(2);
            check({rfs_p.oe, rfs_p.o}, {1'h1, 1'(v)});
        end
        cfg.receive_frame_sync_direction = 1'h0;
        step(2);
        check(rfs_p.oe, 1'h0);
    endtask : t_flags
    // codec bit clock reaches receivers when asynchronous
    task automatic t_bitclk();
        int rises;
        int highs;
        rises = 0;
        highs = 0;
        cfg = '0;
        cfg.sck_serial_en = 1'h1;
        run = 1'h1;
        repeat (80)
        begin
            step(1);
            rises += int'(rx_rise === 1'h1);
            highs += int'(rx_bck === 1'h1);
        end
        // ten codec periods: one pulse per rise, clock high half the time
        check({rises >= 9, rises <= 11}, 2'h3);
        check({highs >= 32, highs <= 48}, 2'h3);
        run = 1'h0;
    endtask : t_bitclk
    initial
    begin
        step(20);
        reset_n = 1'h1;
        step(2);
        t_gpio();
        t_frames();
        t_flags();
        t_bitclk();
        close_out();
    end
    // hang guard, far beyond the few hundred cycles used
    initial
    begin
        #200000;
        err_count++;
        close_out();
    end
endmodule : asfs_pins_tb
bind asfs_pins asfs_pins_asserts u_chk (.clk_sys(clk_sys),
    .reset_n(reset_n), .clk_en(clk_en), .cfg(cfg), .gpio(gpio),
    .core(core), .output_flag_one(output_flag_one),
    .receive_frame_sync_pin(receive_frame_sync_pin),
    .transmit_frame_sync_pin(transmit_frame_sync_pin),
    .rx_frame_sync(rx_frame_sync), .tx_frame_sync(tx_frame_sync));
